// File: logic/pllps_map.vh
// register offsets, field positions and reset values for the pll group three profile block
`ifndef PLLPS_MAP_VH
`define PLLPS_MAP_VH
`define PLLPS_ADDR_W 8
`define PLLPS_OFF_SPREAD_HI 8'h30
`define PLLPS_OFF_SPREAD_MID 8'h31
`define PLLPS_OFF_SPREAD_LO 8'h32
`define PLLPS_OFF_VCO_SEL 8'h33
`define PLLPS_OFF_MUX_STATE 8'h34
`define PLLPS_OFF_STATE_SEL 8'h35
`define PLLPS_OFF_DIR_DIV6 8'h36
`define PLLPS_OFF_DIV7 8'h37
`define PLLPS_OFF_LIMIT 8'h40
`define PLLPS_RST_SPREAD_HI 8'h00
`define PLLPS_RST_SPREAD_MID 8'h00
`define PLLPS_RST_SPREAD_LO 8'h00
`define PLLPS_RST_VCO_SEL 8'h00
`define PLLPS_RST_MUX_STATE 8'hED
`define PLLPS_RST_STATE_SEL 8'h02
`define PLLPS_RST_DIR_DIV6 8'h01
`define PLLPS_RST_DIV7 8'h01
`define PLLPS_BIT_BYPASS 7
`define PLLPS_BIT_M6 6
`define PLLPS_BIT_DIR 7
`define PLLPS_M7_HI 5
`define PLLPS_M7_LO 4
`define PLLPS_STB_HI 3
`define PLLPS_STB_LO 2
`define PLLPS_STA_HI 1
`define PLLPS_STA_LO 0
`define PLLPS_SRC_DIV4 2'h0
`define PLLPS_SRC_DIV6 2'h1
`define PLLPS_SRC_DIV7 2'h2
`define PLLPS_ST_OFF_PD 2'h0
`define PLLPS_ST_TRI 2'h1
`define PLLPS_ST_LOW 2'h2
`define PLLPS_ST_ON 2'h3
`define PLLPS_RST_BYPASS 1'h1
`define PLLPS_RST_PD 1'h1
`define PLLPS_RST_SIX_SRC 1'h1
`define PLLPS_RST_DIV 7'h01
`endif

// File: logic/pllps_out_state.v
// decodes a two-bit output-state definition into pin controls
`timescale 1ns/1ps
`default_nettype none
`include "pllps_map.vh"
module pllps_out_state (
  input wire [1:0] i_state, // selected state definition
  output wire o_drive_en, // outputs driven (not 3-state)
  output wire o_force_low, // outputs held low
  output wire o_pll_pd // state also powers the pll down
);
  assign o_drive_en = (i_state == `PLLPS_ST_LOW) || (i_state == `PLLPS_ST_ON);
  assign o_force_low = (i_state == `PLLPS_ST_LOW);
  assign o_pll_pd = (i_state == `PLLPS_ST_OFF_PD);
endmodule // pllps_out_state
`default_nettype wire

// File: logic/pllps_top.v
// pll group three profile selection and configuration registers
// Function
// - eight 3-bit spread amount codes, one per profile, some split across bytes
// - one bit picks down-spread (0) or center-spread (1)
// - per-profile bit picks first (0) or second (1) vco setting
// - bypass bit 1 bypasses and powers down pll, default 1
// - output six source: 0 divider four, 1 divider six, default 1
// - output seven source: 00 div4, 01 div6, 10 div7, 11 reserved
// - state codes: 00 3-state plus pll down, 01 3-state, 10 low, 11 on
// - per-profile bit applies state definition a (0) or b (1)
// - eight stored profiles, chosen by three control pins
// - fields take listed defaults after reset
// - configuration bytes travel msb first
// - divider value 0 means reset and standby, 1..127 the ratio
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pllps_map.vh"
module pllps_top (
  input wire i_sys_clk, // system clock, 40 MHz
  input wire i_srst, // synchronous reset, active high
  input wire [7:0] i_addr, // register byte offset
  input wire [7:0] i_wdata, // write data, bit 7 is the first serial bit
  input wire i_wr, // write strobe
  input wire i_rd, // read strobe
  input wire i_control_pin_zero, // profile select bit 0
  input wire i_control_pin_one, // profile select bit 1
  input wire i_control_pin_two, // profile select bit 2
  output reg [7:0] o_rdata, // read data, one cycle after strobe
  output reg [2:0] o_profile, // active profile index
  output reg [2:0] o_spread_amount_code, // active spread amount, 0 = off
  output reg o_spread_direction_bit, // 0 down, 1 center
  output reg o_vco_setting_select_bit, // 0 first, 1 second vco setting
  output reg o_pll_bypass, // pll bypassed
  output reg o_pll_power_down, // pll powered down
  output reg o_out_six_source_select, // 0 div4, 1 div6
  output reg [1:0] o_out_seven_source_select, // 00 div4, 01 div6, 10 div7
  output reg o_out_seven_source_bad, // reserved code programmed
  output reg o_clock_out_drive_en, // outputs six and seven driven
  output reg o_clock_out_force_low, // outputs six and seven held low
  output reg [6:0] o_divider_out_six, // div6 ratio
  output reg o_divider_out_six_standby, // div6 in reset and standby
  output reg [6:0] o_divider_out_seven, // div7 ratio
  output reg o_divider_out_seven_standby // div7 in reset and standby
);
  reg [7:0] spread_hi_reg;
  reg [7:0] spread_mid_reg;
  reg [7:0] spread_lo_reg;
  reg [7:0] vco_sel_reg;
  reg [7:0] mux_state_reg;
  reg [7:0] state_sel_reg;
  reg [7:0] dir_div6_reg;
  reg [7:0] div7_reg;
  reg [7:0] rdata_next;
  wire [23:0] spread_all;
  wire [2:0] prof_next;
  wire [2:0] codes [0:7];
  wire [1:0] state_sel;
  wire st_drive_en;
  wire st_force_low;
  wire st_pll_pd;
  wire [1:0] prof_state [0:7];
  wire wr_spread_hi;
  wire wr_spread_mid;
  wire wr_spread_lo;
  wire wr_vco_sel;
  wire wr_mux_state;
  wire wr_state_sel;
  wire wr_dir_div6;
  wire wr_div7;

  // profile 7 code sits at the top of 30h, profile 0 at the bottom of 32h
  assign spread_all = {spread_hi_reg, spread_mid_reg, spread_lo_reg};
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_code
      assign codes[gi] = spread_all[gi*3+2:gi*3];
      assign prof_state[gi] = state_sel_reg[gi] ? mux_state_reg[`PLLPS_STB_HI:`PLLPS_STB_LO]
                                                : mux_state_reg[`PLLPS_STA_HI:`PLLPS_STA_LO];
    end
  endgenerate

  assign prof_next = {i_control_pin_two, i_control_pin_one, i_control_pin_zero};
  assign state_sel = prof_state[prof_next];

  pllps_out_state u_state (
    .i_state(state_sel),
    .o_drive_en(st_drive_en),
    .o_force_low(st_force_low),
    .o_pll_pd(st_pll_pd)
  );

  // write enables; offsets 38h..3Fh and above are accepted but not stored here
  // split codes straddle bytes, so software rewrites all three spread bytes together
  assign wr_spread_hi = i_wr && (i_addr == `PLLPS_OFF_SPREAD_HI);
  assign wr_spread_mid = i_wr && (i_addr == `PLLPS_OFF_SPREAD_MID);
  assign wr_spread_lo = i_wr && (i_addr == `PLLPS_OFF_SPREAD_LO);
  assign wr_vco_sel = i_wr && (i_addr == `PLLPS_OFF_VCO_SEL);
  assign wr_mux_state = i_wr && (i_addr == `PLLPS_OFF_MUX_STATE);
  assign wr_state_sel = i_wr && (i_addr == `PLLPS_OFF_STATE_SEL);
  assign wr_dir_div6 = i_wr && (i_addr == `PLLPS_OFF_DIR_DIV6);
  assign wr_div7 = i_wr && (i_addr == `PLLPS_OFF_DIV7);

  // 30h: codes of profiles 7 and 6, top two bits of profile 5
  always @(posedge i_sys_clk) begin
    if (i_srst) begin
      spread_hi_reg <= `PLLPS_RST_SPREAD_HI;
    end else if (wr_spread_hi) begin
      spread_hi_reg <= i_wdata;
    end
  end

  // 31h: rest of profile 5, profiles 4 and 3, top bit of profile 2
  always @(posedge i_sys_clk) begin
    if (i_srst) begin
      spread_mid_reg <= `PLLPS_RST_SPREAD_MID;
    end else if (wr_spread_mid) begin
      spread_mid_reg <= i_wdata;
    end
  end

  // 32h: rest of profile 2, profiles 1 and 0
  always @(posedge i_sys_clk) begin
    if (i_srst) begin
      spread_lo_reg <= `PLLPS_RST_SPREAD_LO;
    end else if (wr_spread_lo) begin
      spread_lo_reg <= i_wdata;
    end
  end

  // 33h: one vco setting select bit per profile
  always @(posedge i_sys_clk) begin
    if (i_srst) begin
      vco_sel_reg <= `PLLPS_RST_VCO_SEL;
    end else if (wr_vco_sel) begin
      vco_sel_reg <= i_wdata;
    end
  end

  // 34h: bypass, output sources and the two state definitions
  always @(posedge i_sys_clk) begin
    if (i_srst) begin
      mux_state_reg <= `PLLPS_RST_MUX_STATE;
    end else if (wr_mux_state) begin
      mux_state_reg <= i_wdata;
    end
  end

  // 35h: one state select bit per profile
  always @(posedge i_sys_clk) begin
    if (i_srst) begin
      state_sel_reg <= `PLLPS_RST_STATE_SEL;
    end else if (wr_state_sel) begin
      state_sel_reg <= i_wdata;
    end
  end

  // 36h: spread direction and divider six
  always @(posedge i_sys_clk) begin
    if (i_srst) begin
      dir_div6_reg <= `PLLPS_RST_DIR_DIV6;
    end else if (wr_dir_div6) begin
      dir_div6_reg <= i_wdata;
    end
  end

  // 37h: divider seven; bit 7 is reserved and kept zero
  always @(posedge i_sys_clk) begin
    if (i_srst) begin
      div7_reg <= `PLLPS_RST_DIV7;
    end else if (wr_div7) begin
      div7_reg <= {1'h0, i_wdata[6:0]};
    end
  end

  // byte bit 7 corresponds to the first bit on the serial wire
  always @* begin
    case (i_addr)
      `PLLPS_OFF_SPREAD_HI: rdata_next = spread_hi_reg;
      `PLLPS_OFF_SPREAD_MID: rdata_next = spread_mid_reg;
      `PLLPS_OFF_SPREAD_LO: rdata_next = spread_lo_reg;
      `PLLPS_OFF_VCO_SEL: rdata_next = vco_sel_reg;
      `PLLPS_OFF_MUX_STATE: rdata_next = mux_state_reg;
      `PLLPS_OFF_STATE_SEL: rdata_next = state_sel_reg;
      `PLLPS_OFF_DIR_DIV6: rdata_next = dir_div6_reg;
      `PLLPS_OFF_DIV7: rdata_next = div7_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  // read data stands for the one cycle after the strobe, zero otherwise
  always @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      o_rdata <= rdata_next;
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // pins are taken as synchronous; no resync stage in front of them
  always @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_profile <= 3'h0;
    end else begin
      o_profile <= prof_next;
    end
  end

  // amount code of the active profile, 0 is modulation off
  always @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_spread_amount_code <= 3'h0;
    end else begin
      o_spread_amount_code <= codes[prof_next];
    end
  end

  // down or center spread, common to all profiles
  always @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_spread_direction_bit <= 1'h0;
    end else begin
      o_spread_direction_bit <= dir_div6_reg[`PLLPS_BIT_DIR];
    end
  end

  // vco setting of the active profile
  always @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_vco_setting_select_bit <= 1'h0;
    end else begin
      o_vco_setting_select_bit <= vco_sel_reg[prof_next];
    end
  end

  // bypass routes around the pll
  always @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_pll_bypass <= `PLLPS_RST_BYPASS;
    end else begin
      o_pll_bypass <= mux_state_reg[`PLLPS_BIT_BYPASS];
    end
  end

  // a state definition of 00 also powers the pll down
  // bypass always powers down, whatever state the profile selects
  always @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_pll_power_down <= `PLLPS_RST_PD;
    end else begin
      o_pll_power_down <= mux_state_reg[`PLLPS_BIT_BYPASS] | st_pll_pd;
    end
  end

  // output six takes divider four or divider six
  always @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_out_six_source_select <= `PLLPS_RST_SIX_SRC;
    end else begin
      o_out_six_source_select <= mux_state_reg[`PLLPS_BIT_M6];
    end
  end

  // reserved code passed through; flagged so the mux can park safely
  always @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_out_seven_source_select <= `PLLPS_SRC_DIV7;
    end else begin
      o_out_seven_source_select <= mux_state_reg[`PLLPS_M7_HI:`PLLPS_M7_LO];
    end
  end

  // reserved output seven source programmed
  always @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_out_seven_source_bad <= 1'h0;
    end else begin
      o_out_seven_source_bad <= (mux_state_reg[`PLLPS_M7_HI:`PLLPS_M7_LO] == 2'h3);
    end
  end

  // both outputs of the group follow one state, never each its own
  // states 10 and 11 drive the pins, 00 and 01 leave them 3-state
  always @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_clock_out_drive_en <= 1'h0;
    end else begin
      o_clock_out_drive_en <= st_drive_en;
    end
  end

  // state 10 holds the pins low instead of toggling
  always @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_clock_out_force_low <= 1'h0;
    end else begin
      o_clock_out_force_low <= st_force_low;
    end
  end

  // divider six ratio
  always @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_divider_out_six <= `PLLPS_RST_DIV;
    end else begin
      o_divider_out_six <= dir_div6_reg[6:0];
    end
  end

  // ratio 0 parks divider six in reset and standby
  always @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_divider_out_six_standby <= 1'h0;
    end else begin
      o_divider_out_six_standby <= (dir_div6_reg[6:0] == 7'h00);
    end
  end

  // divider seven ratio
  always @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_divider_out_seven <= `PLLPS_RST_DIV;
    end else begin
      o_divider_out_seven <= div7_reg[6:0];
    end
  end

  // ratio 0 parks divider seven in reset and standby
  always @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_divider_out_seven_standby <= 1'h0;
    end else begin
      o_divider_out_seven_standby <= (div7_reg[6:0] == 7'h00);
    end
  end
endmodule // pllps_top
`default_nettype wire

// File: tb/pllps_properties.sv
// port assertions for the pll group three profile block
`timescale 1ns/1ps
`default_nettype none
module pllps_properties (
  input wire logic i_sys_clk, i_srst, i_wr, i_rd, i_control_pin_zero, i_control_pin_one, i_control_pin_two, // in
  input wire logic [7:0] i_addr, i_wdata, o_rdata, // register port
  input wire logic [2:0] o_profile, // active profile
  input wire logic [1:0] o_out_seven_source_select, // output seven source
  input wire logic [6:0] o_divider_out_six, // divider six ratio
  input wire logic o_pll_bypass, o_pll_power_down, o_out_six_source_select, o_out_seven_source_bad, // pll
  input wire logic o_clock_out_drive_en, o_clock_out_force_low, o_divider_out_six_standby // output state
);
  wire [2:0] pin_idx = {i_control_pin_two, i_control_pin_one, i_control_pin_zero};
  wire mux_wr = i_wr && i_addr == 8'h34;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  a_unmapped_read: assert property (i_rd && i_addr > 8'h37 |=> o_rdata == 8'h00) else $error("unmapped read");
  a_profile_pins: assert property (!$past(i_srst) |-> o_profile == $past(pin_idx)) else $error("profile index");
  a_bypass_pd: assert property (o_pll_bypass |-> o_pll_power_down) else $error("bypass not powered down");
  a_seven_bad: assert property (o_out_seven_source_bad == (o_out_seven_source_select == 2'h3))
    else $error("reserved flag");
  a_low_driven: assert property (o_clock_out_force_low |-> o_clock_out_drive_en) else $error("low state");
  a_div_standby: assert property (o_divider_out_six_standby == (o_divider_out_six == 7'h00))
    else $error("divider standby");
  a_wr_bypass: assert property ($past(mux_wr, 2) && !$past(i_srst) |-> o_pll_bypass == $past(i_wdata[7], 2))
    else $error("bypass write");
  a_wr_six_src: assert property ($past(mux_wr, 2) && !$past(i_srst) |-> o_out_six_source_select == $past(i_wdata[6], 2))
    else $error("output six source write");
  c_mux_wr: cover property (mux_wr);
  c_reserved: cover property (o_out_seven_source_bad);
  c_state_pd: cover property (o_pll_power_down && !o_pll_bypass);
endmodule // pllps_properties
bind pllps_top pllps_properties u_props (.*);
`default_nettype wire

// File: tb/pllps_host.sv
// host model for the register port
`timescale 1ns/1ps
`default_nettype none
module pllps_host (
  input wire logic i_sys_clk, // bench clock
  output logic [7:0] o_addr = 8'h00, // register offset
  output logic [7:0] o_wdata = 8'h00, // write byte, bit 7 is sent first
  output logic o_wr = 1'b0, // write strobe
  output logic o_rd = 1'b0 // read strobe
);
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    if (!w || a < 8'h40) begin
      o_addr <= a;
      o_wdata <= d;
      o_wr <= w;
      o_rd <= !w;
      @(posedge i_sys_clk);
      o_wr <= 1'b0;
      o_rd <= 1'b0;
      o_wdata <= ~d; // released bus must not keep its last byte
    end
  endtask
endmodule // pllps_host
`default_nettype wire

// File: tb/pllps_top_tb_top.sv
// self-checking bench for the pll group three profile block
`timescale 1ns/1ps
`default_nettype none
module pllps_top_tb_top;
  logic clk = 1'b0, srst = 1'b1, wr, rd, rd_d = 1'b0, dir, vco, byp, pd, s6, bad, drv, low, sb6, sb7;
  logic [7:0] addr, wdata, rdata, a, q [$], r [0:9];
  logic [7:0] rv [0:7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hED, 8'h02, 8'h01, 8'h01};
  logic [2:0] pins = 3'h0, prof, code;
  logic [1:0] s7, st;
  logic [6:0] d6, d7;
  logic [23:0] sp;
  integer seed = 32'h18fec3bd, err_total = 0, n_compared = 0, cyc = 0, k, p;
  initial forever #12.5 clk = ~clk;
  pllps_host h (.i_sys_clk(clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
  pllps_top uut (.i_sys_clk(clk), .i_srst(srst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .i_control_pin_zero(pins[0]), .i_control_pin_one(pins[1]), .i_control_pin_two(pins[2]), .o_rdata(rdata),
    .o_profile(prof), .o_spread_amount_code(code), .o_spread_direction_bit(dir), .o_vco_setting_select_bit(vco),
    .o_pll_bypass(byp), .o_pll_power_down(pd), .o_out_six_source_select(s6), .o_out_seven_source_select(s7),
    .o_out_seven_source_bad(bad), .o_clock_out_drive_en(drv), .o_clock_out_force_low(low), .o_divider_out_six(d6),
    .o_divider_out_six_standby(sb6), .o_divider_out_seven(d7), .o_divider_out_seven_standby(sb7));
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    n_compared = n_compared + 1;
    if (s !== e) begin
      err_total = err_total + 1;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    rd_d <= rd;
    cyc <= cyc + 1;
    if (rd_d) chk("rdata", rdata, q.pop_front());
    if (cyc == 3000) begin
      err_total = err_total + 1;
      tally_and_finish;
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    // defaults first, then a write read straight back; 40h and up stay empty
    for (k = 0; k < 10; k++) begin
      a = k < 8 ? 8'h30 + 8'(k) : 8'h38 + 8'(k);
      r[k] = 8'($random(seed));
      q.push_back(k < 8 ? rv[k] : 8'h00);
      h.xfer(1'b0, a, 8'h00);
      h.xfer(1'b1, a, r[k]);
      q.push_back(k > 7 ? 8'h00 : k == 7 ? r[k] & 8'h7F : r[k]);
      h.xfer(1'b0, a, 8'h00);
    end
    settle;
    chk("direction", dir, r[6][7]);
    chk("div6_standby", sb6, r[6][6:0] == 7'h00);
    chk("div7", d7, r[7][6:0]);
    chk("div6", d6, r[6][6:0]);
    chk("div7_standby", sb7, r[7][6:0] == 7'h00);
    chk("bypass", byp, r[4][7]);
    chk("six_src", s6, r[4][6]);
    // zero ratios park both dividers; 37h is written 80h, only its reserved bit set
    h.xfer(1'b1, 8'h36, 8'h80);
    h.xfer(1'b1, 8'h37, 8'h80);
    settle;
    chk("direction", dir, 1'b1);
    chk("div6_standby", sb6, 1'b1);
    chk("div7_standby", sb7, 1'b1);
    chk("div7", d7, 8'h00);
    sp = {r[0], r[1], r[2]};
    for (k = 0; k < 4; k++) begin
      h.xfer(1'b1, 8'h34, {1'b0, k[0], k[1:0], k[1:0], ~k[1:0]});
      settle;
      chk("seven_src", s7, k[1:0]);
      chk("seven_bad", bad, k == 3);
      chk("bypass", byp, 1'b0);
      chk("six_src", s6, k[0]);
      for (p = 0; p < 8; p++) begin
        @(posedge clk);
        pins <= p[2:0];
        settle;
        st = r[5][p] ? k[1:0] : ~k[1:0];
        chk("profile", prof, p[2:0]);
        chk("spread", code, sp[3 * p +: 3]);
        chk("vco_sel", vco, r[3][p]);
        chk("drive_en", drv, st[1]);
        chk("force_low", low, st == 2'h2);
        chk("power_down", pd, st == 2'h0);
      end
    end
    // bypass must power the pll down even with the outputs enabled
    h.xfer(1'b1, 8'h34, 8'hFF);
    settle;
    chk("bypass_pd", pd, 1'b1);
    chk("bypass_drive", drv, 1'b1);
    settle;
    tally_and_finish;
  end
endmodule // pllps_top_tb_top
`default_nettype wire
